// File: hw/rnp_reset_nmi.sv
// reset pin and unmaskable interrupt pin conditioning with power-down gating
//
// Behaviour
// - low reset pin while the clock runs holds the core in reset
// - reset filter drops lows under 10 ns, passes lows over 100 ns
// - falling interrupt pin edge requests the trap routine vector
// - power-down instruction enters power-down only while interrupt pin is low
`timescale 1ns/1ps
`default_nettype none
module rnp_reset_nmi
  import rnp_pkg::*;
#(
  parameter int unsigned RST_FILTER_SAMPLES = RST_SAMPLES,
  parameter int unsigned NMI_FILTER_SAMPLES = NMI_SAMPLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic system_reset_in_n,
  input  wire logic nmi_in_n,
  input  wire logic power_down_instruction,
  output logic      core_reset_n,
  output logic      nmi_trap_req,
  output logic      power_down_enter,
  output logic      power_down_refused,
  output logic      power_down_active
);

  localparam int unsigned PIN_COUNT = 2;
  localparam int unsigned PIN_RST   = 0;
  localparam int unsigned PIN_NMI   = 1;

  // latency from a pin change to the ports, in clock edges:
  // two synchroniser flops, the sample history, the filtered level,
  // then the output register in this module;
  // a reset low seen at two edges shows on core_reset_n five edges on,
  // an interrupt fall shows on nmi_trap_req four edges on

  // a pass window under two samples could not tell a spike from a pulse
  if (RST_PASS_CYC < 2) begin : g_bad_window
    $error("rnp_reset_nmi: pass window shorter than two samples");
  end

  // one sample would let a spike over a single edge reset the core
  if (RST_FILTER_SAMPLES < 2 || RST_FILTER_SAMPLES > RST_PASS_CYC) begin : g_bad_rst
    $error("rnp_reset_nmi: RST_FILTER_SAMPLES out of range");
  end

  // deeper than the pass window would also drop edges that must pass
  if (NMI_FILTER_SAMPLES < 1 || NMI_FILTER_SAMPLES > RST_PASS_CYC) begin : g_bad_nmi
    $error("rnp_reset_nmi: NMI_FILTER_SAMPLES out of range");
  end

  // a low idle level would keep the core in reset after every rst_n
  if (PIN_IDLE_LEVEL != 1'h1) begin : g_bad_idle
    $error("rnp_reset_nmi: pin idle level must be high");
  end

  // a pulse that woke up active would fire a false trap or power-down
  if (PULSE_RST_VALUE != 1'h0) begin : g_bad_pulse
    $error("rnp_reset_nmi: pulses must reset inactive");
  end

  // power-down must not survive a reset
  if (PD_RST_VALUE != 1'h0) begin : g_bad_pd
    $error("rnp_reset_nmi: power-down must reset off");
  end

  // run: instruction is judged against the interrupt pin
  // down: left only through a reset; no other wake source exists
  typedef enum logic [1:0] {
    PM_RUN  = 2'b01,
    PM_DOWN = 2'b10
  } rnp_pm_t;

  typedef struct packed {
    logic    reset_out_n;
    logic    trap;
    logic    pd_enter;
    logic    pd_refused;
    logic    pd_active;
    rnp_pm_t mode;
  } rnp_state_t;

  localparam rnp_state_t S_RESET = '{
    reset_out_n: 1'h0,
    trap:        PULSE_RST_VALUE,
    pd_enter:    PULSE_RST_VALUE,
    pd_refused:  PULSE_RST_VALUE,
    pd_active:   PD_RST_VALUE,
    mode:        PM_RUN
  };

  function automatic int unsigned pin_depth(input int unsigned idx);
    int unsigned depth;
    depth = NMI_FILTER_SAMPLES;
    if (idx == PIN_RST) begin
      depth = RST_FILTER_SAMPLES;
    end
    return depth;
  endfunction

  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_level;
  logic [PIN_COUNT-1:0] pin_fall;
  logic                 rst_level;
  logic                 nmi_level;
  logic                 nmi_fall;
  logic                 in_reset;
  logic                 pd_request;
  logic                 pd_allowed;
  logic                 pd_idle;
  logic                 trap_take;
  logic                 pd_take;
  logic                 pd_deny;
  rnp_state_t           s_reg;
  rnp_state_t           s_next;

  rnp_pin_if pin_bus [PIN_COUNT] ();

  assign pin_raw[PIN_RST] = system_reset_in_n;
  assign pin_raw[PIN_NMI] = nmi_in_n;

  // one conditioner per pin; the filter needs clock edges,
  // so with the oscillator stopped the pin is not seen
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    rnp_pin_cond #(
      .SAMPLES (pin_depth(i))
    ) rnp_pin_cond_inst (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin_in  (pin_raw[i]),
      .pin_out (pin_bus[i].cond)
    );

    assign pin_level[i] = pin_bus[i].level;
    assign pin_fall[i]  = pin_bus[i].fall;
  end

  assign rst_level  = pin_level[PIN_RST];
  assign nmi_level  = pin_level[PIN_NMI];
  assign nmi_fall   = pin_fall[PIN_NMI];
  assign in_reset   = ~rst_level;
  assign pd_request = power_down_instruction & ~in_reset;
  // the interrupt pin level gates power-down
  assign pd_allowed = ~nmi_level;

  // single-cycle events of this edge; the filtered reset masks them all
  assign pd_idle   = (s_reg.mode == PM_RUN);
  assign trap_take = nmi_fall & ~in_reset;
  assign pd_take   = pd_request & pd_idle & pd_allowed;
  assign pd_deny   = pd_request & pd_idle & ~pd_allowed;

  always_comb begin
    s_next             = s_reg;
    s_next.reset_out_n = rst_level;
    s_next.trap        = trap_take;
    s_next.pd_enter    = pd_take;
    s_next.pd_refused  = pd_deny;
    if (in_reset) begin
      // reset clears power-down; configuration settling is the board's concern
      s_next.pd_active = PD_RST_VALUE;
      s_next.mode      = PM_RUN;
    end else begin
      unique case (s_reg.mode)
        PM_RUN: begin
          if (pd_take) begin
            s_next.pd_active = 1'h1;
            s_next.mode      = PM_DOWN;
          end
        end

        PM_DOWN: begin
          // a repeated instruction is ignored while down
          s_next.pd_active = 1'h1;
        end

        default: begin
          // two bits can hold codes the machine never uses
          s_next.pd_active = PD_RST_VALUE;
          s_next.mode      = PM_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= S_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // every output is a register bit: pulses stand one cycle,
  // power_down_active stands until a reset of either kind
  assign core_reset_n       = s_reg.reset_out_n;
  assign nmi_trap_req       = s_reg.trap;
  assign power_down_enter   = s_reg.pd_enter;
  assign power_down_refused = s_reg.pd_refused;
  assign power_down_active  = s_reg.pd_active;
endmodule
`default_nettype wire

// File: hw/rnp_pkg.sv
// constants for the reset and unmaskable interrupt pin conditioning
package rnp_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned RST_REJECT_NS   = 10;
  localparam int unsigned RST_PASS_NS     = 100;
  // samples a low level must persist; shorter than one period cannot cover two edges
  localparam int unsigned RST_SAMPLES     = RST_REJECT_NS / CLK_PERIOD_NS + 2;
  localparam int unsigned RST_PASS_CYC    = RST_PASS_NS / CLK_PERIOD_NS;
  localparam int unsigned NMI_SAMPLES     = 1;
  localparam logic        PIN_IDLE_LEVEL  = 1'h1;
  localparam logic        PULSE_RST_VALUE = 1'h0;
  localparam logic        PD_RST_VALUE    = 1'h0;
endpackage

// File: hw/rnp_pin_if.sv
// conditioned pin level and its falling-edge pulse
`timescale 1ns/1ps
`default_nettype none
interface rnp_pin_if;
  logic level;
  logic fall;
  modport cond (output level, output fall);
  modport user (input level, input fall);
endinterface
`default_nettype wire

// File: hw/rnp_pin_cond.sv
// two-flop synchroniser, sample filter and fall detector for one pin
`timescale 1ns/1ps
`default_nettype none
module rnp_pin_cond
  import rnp_pkg::*;
#(
  parameter int unsigned SAMPLES = 1
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pin_in,
  rnp_pin_if.cond   pin_out
);
  // deeper than the pass window would drop pulses that must get through
  if (SAMPLES < 1 || SAMPLES > RST_PASS_CYC) begin : g_bad_samples
    $error("rnp_pin_cond: SAMPLES out of range");
  end

  typedef struct packed {
    logic               sync1;
    logic               sync2;
    logic [SAMPLES-1:0] hist;
    logic               level;
    logic               fall;
  } rnp_cond_t;

  rnp_cond_t s_reg;
  rnp_cond_t s_next;

  always_comb begin
    logic [SAMPLES:0] ext;
    ext          = {s_reg.hist, s_reg.sync2};
    s_next       = s_reg;
    s_next.sync1 = pin_in;
    s_next.sync2 = s_reg.sync1;
    s_next.hist  = ext[SAMPLES-1:0];
    // level moves only once every held sample agrees
    if (~|s_reg.hist) begin
      s_next.level = 1'h0;
    end else if (&s_reg.hist) begin
      s_next.level = 1'h1;
    end
    s_next.fall  = s_reg.level & ~s_next.level;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{sync1: PIN_IDLE_LEVEL, sync2: PIN_IDLE_LEVEL, hist: {SAMPLES{PIN_IDLE_LEVEL}},
                 level: PIN_IDLE_LEVEL, fall: PULSE_RST_VALUE};
    end else begin
      s_reg <= s_next;
    end
  end

  assign pin_out.level = s_reg.level;
  assign pin_out.fall  = s_reg.fall;
endmodule
`default_nettype wire

// File: test/rnp_reset_nmi_asserts.sv
// port assertions for the reset and interrupt pin conditioning
`timescale 1ns/1ps
`default_nettype none
module rnp_reset_nmi_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic system_reset_in_n,
  input wire logic nmi_in_n,
  input wire logic power_down_instruction,
  input wire logic core_reset_n,
  input wire logic nmi_trap_req,
  input wire logic power_down_enter,
  input wire logic power_down_refused,
  input wire logic power_down_active
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  wire logic pd_ok = power_down_instruction && core_reset_n && !power_down_active;
  property p_rst; !system_reset_in_n[*3] |-> ##[1:4] !core_reset_n; endproperty
  a_rst: assert property (p_rst) else $error("reset pin not taken");
  property p_glitch; $rose(system_reset_in_n) && $past(system_reset_in_n, 2) && core_reset_n |=> core_reset_n[*6]; endproperty
  a_glitch: assert property (p_glitch) else $error("spike reset the core");
  property p_trap; $fell(nmi_in_n) && core_reset_n |-> ##[2:6] nmi_trap_req; endproperty
  a_trap: assert property (p_trap) else $error("no trap after fall");
  property p_pd_on; !nmi_in_n[*6] ##0 pd_ok |=> power_down_enter && power_down_active; endproperty
  a_pd_on: assert property (p_pd_on) else $error("power-down not entered");
  property p_pd_off; nmi_in_n[*6] ##0 pd_ok |=> power_down_refused && !power_down_enter; endproperty
  a_pd_off: assert property (p_pd_off) else $error("power-down not refused");
  c_trap: cover property (nmi_trap_req);
  c_enter: cover property (power_down_enter);
  c_refused: cover property (power_down_refused);
endmodule
bind rnp_reset_nmi rnp_reset_nmi_asserts rnp_reset_nmi_asserts_inst (.*);
`default_nettype wire

// File: test/rnp_board.sv
// board model driving the reset and interrupt pins
`timescale 1ns/1ps
`default_nettype none
module rnp_board (
  input  wire logic clk_sys,
  output var  logic system_reset_in_n,
  output var  logic nmi_in_n
);
  initial system_reset_in_n = 1'h1;
  // pulled high when unused
  initial nmi_in_n = 1'h1;
  // 8 clocks is 200 ns, over 100 ns plus two clocks
  task automatic hold_rst();
    @(posedge clk_sys) system_reset_in_n <= 1'h0;
    repeat (8) @(posedge clk_sys);
    system_reset_in_n <= 1'h1;
  endtask
  // 8 ns low straddling one edge: sampled once, still a spike
  task automatic glitch();
    @(negedge clk_sys) #8 system_reset_in_n = 1'h0;
    #8 system_reset_in_n = 1'h1;
  endtask
  task automatic set_nmi(input logic v);
    @(posedge clk_sys) nmi_in_n <= v;
  endtask
endmodule
`default_nettype wire

// File: test/rnp_reset_nmi_tb.sv
// self-checking bench for the reset and interrupt pin conditioning
`timescale 1ns/1ps
`default_nettype none
module rnp_reset_nmi_tb;
  logic      clk_sys = 1'h0;
  logic      rst_n = 1'h0;
  logic      power_down_instruction = 1'h0;
  wire logic system_reset_in_n, nmi_in_n, core_reset_n, nmi_trap_req;
  wire logic power_down_enter, power_down_refused, power_down_active;
  int        error_cnt = 0;
  int        comparisons = 0;
  always #12.5 clk_sys = ~clk_sys;
  rnp_board rnp_board_inst (
    .clk_sys           (clk_sys),
    .system_reset_in_n (system_reset_in_n),
    .nmi_in_n          (nmi_in_n)
  );
  rnp_reset_nmi rnp_reset_nmi_inst (
    .clk_sys                (clk_sys),
    .rst_n                  (rst_n),
    .system_reset_in_n      (system_reset_in_n),
    .nmi_in_n               (nmi_in_n),
    .power_down_instruction (power_down_instruction),
    .core_reset_n           (core_reset_n),
    .nmi_trap_req           (nmi_trap_req),
    .power_down_enter       (power_down_enter),
    .power_down_refused     (power_down_refused),
    .power_down_active      (power_down_active)
  );
  task automatic chk(input string n, input logic e, input logic s);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %b got %b", n, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_nmi();
    int k = 0;
    rnp_board_inst.set_nmi(1'h0);
    while (nmi_trap_req !== 1'h1 && k < 8) begin
      @(negedge clk_sys);
      k++;
    end
    chk("trap", 1'h1, nmi_trap_req);
    @(negedge clk_sys);
    chk("trap pulse", 1'h0, nmi_trap_req);
  endtask
  // pin low must enter, pin high must refuse
  task automatic t_pd(input logic pin);
    rnp_board_inst.set_nmi(pin);
    repeat (6) @(posedge clk_sys);
    power_down_instruction <= 1'h1;
    @(posedge clk_sys) power_down_instruction <= 1'h0;
    @(negedge clk_sys);
    chk("enter", ~pin, power_down_enter);
    chk("refused", pin, power_down_refused);
    chk("active", ~pin, power_down_active);
  endtask
  task automatic t_rst();
    rnp_board_inst.glitch();
    repeat (8) @(negedge clk_sys);
    chk("spike", 1'h1, core_reset_n);
    rnp_board_inst.hold_rst();
    @(negedge clk_sys);
    chk("reset", 1'h0, core_reset_n);
    chk("pd cleared", 1'h0, power_down_active);
    repeat (8) @(negedge clk_sys);
    chk("release", 1'h1, core_reset_n);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk_sys);
    t_nmi();
    t_pd(1'h0);
    t_rst();
    t_pd(1'h1);
    wrap_up();
  end
  initial begin
    #20000;
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
